//--- hw/lec_line_error_counters.sv
`timescale 1ns/1ns
module lec_line_error_counters
  import lec_pkg::*;
#(
  parameter int SECOND_FRAMES   = LEC_SECOND_FRAMES,   // frames in one second
  parameter int T1_SHORT_FRAMES = LEC_T1_SHORT_FRAMES, // t1 short interval
  parameter int E1_SHORT_FRAMES = LEC_E1_SHORT_FRAMES  // e1 short interval
)
(
  input  wire logic      mclk,                 // system clock, 250 MHz
  input  wire logic      reset,                // synchronous reset
  input  wire lec_port_s port,                 // parallel port request
  output logic [7:0]     rdata,                // parallel port read data
  input  wire lec_line_s line,                 // received symbol stream
  input  wire lec_mode_s mode,                 // line mode and sync state
  input  wire logic      frame_tick,           // one pulse per received frame
  output logic           update_strobe,        // counts moved to readable copy
  output logic           interval_tick,        // automatic update timer tick
  output logic           sync_counter_function_select, // frame sync counter mode
  output logic           signaling_fbit_report_enable  // fs errors to path counter
);

  lec_main_s st;
  lec_main_s next_st;

  logic                       violation;
  logic                       wr_config;
  logic                       rd_strobe;
  logic                       manual_mode;
  logic                       manual_rise;
  logic                       auto_due;
  logic                       do_update;
  logic [LEC_FRAME_CNT_W-1:0] frame_limit;
  logic [7:0]                 cfg_written;

  // address match on a selected access
  function automatic logic reg_hit(input lec_port_s p, input logic [7:0] a);
    return p.cs && (p.addr == a);
  endfunction

  // saturating increment
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == LEC_COUNT_MAX) ? LEC_COUNT_MAX : v + LEC_COUNT_ONE;
  endfunction

  // line code violation detector
  lec_code_check u_check (
    .mclk                     (mclk),
    .reset                    (reset),
    .line                     (line),
    .mode                     (mode),
    .excess_zero_count_enable (st.error_counter_config[LEC_CFG_EXCESS_ZERO]),
    .e1_violation_type_select (st.error_counter_config[LEC_CFG_E1_VIOL_TYPE]),
    .violation                (violation)
  );

  // port decode
  always_comb begin
    wr_config   = reg_hit(port, LEC_ADDR_CONFIG) & port.wr;
    rd_strobe   = port.cs & port.rd;
    cfg_written = port.wdata & LEC_CFG_WRITE_MASK;
  end

  // interval selection
  always_comb begin
    manual_mode = st.error_counter_config[LEC_CFG_ACC_SOURCE];
    if (!st.error_counter_config[LEC_CFG_AUTO_INTERVAL]) begin
      frame_limit = LEC_FRAME_CNT_W'(SECOND_FRAMES - 1);
    end else if (mode.e1_mode) begin
      frame_limit = LEC_FRAME_CNT_W'(E1_SHORT_FRAMES - 1);
    end else begin
      frame_limit = LEC_FRAME_CNT_W'(T1_SHORT_FRAMES - 1);
    end
    auto_due = ~manual_mode & frame_tick & (st.frame_cnt >= frame_limit);
  end

  // manual update edge detect on the written value
  always_comb begin
    manual_rise = wr_config & manual_mode
                & cfg_written[LEC_CFG_MANUAL]
                & ~st.error_counter_config[LEC_CFG_MANUAL];
    do_update   = st.manual_pend | auto_due;
  end

  // next state
  always_comb begin
    next_st = st;
    next_st.update_strobe = 1'b0;
    next_st.interval_tick = 1'b0;
    next_st.manual_pend   = manual_rise;

    if (wr_config) begin
      next_st.error_counter_config = cfg_written;
    end

    // frame counter runs only for automatic updates
    if (manual_mode) begin
      next_st.frame_cnt = '0;
    end else if (frame_tick) begin
      next_st.frame_cnt = auto_due ? '0 : st.frame_cnt + LEC_FRAME_CNT_W'(1);
    end

    if (violation) begin
      next_st.running = sat_inc(st.running);
    end

    if (do_update) begin
      next_st.latched       = st.running;
      next_st.running       = violation ? LEC_COUNT_ONE : LEC_COUNT_RESET;
      next_st.update_strobe = 1'b1;
      next_st.interval_tick = auto_due;
    end

    next_st.rdata = LEC_RDATA_IDLE;
    if (rd_strobe) begin
      if (reg_hit(port, LEC_ADDR_CONFIG)) begin
        next_st.rdata = st.error_counter_config;
      end else if (reg_hit(port, LEC_ADDR_COUNT_H)) begin
        next_st.rdata = st.latched[15:8];
      end else if (reg_hit(port, LEC_ADDR_COUNT_L)) begin
        next_st.rdata = st.latched[7:0];
      end else begin
        next_st.rdata = LEC_RDATA_IDLE;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st                      <= '0;
      st.error_counter_config <= LEC_CFG_RESET;
      st.running              <= LEC_COUNT_RESET;
      st.latched              <= LEC_COUNT_RESET;
      st.rdata                <= LEC_RDATA_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign rdata         = st.rdata;
  assign update_strobe = st.update_strobe;
  assign interval_tick = st.interval_tick;
  assign sync_counter_function_select = st.error_counter_config[LEC_CFG_SYNC_FUNC];
  assign signaling_fbit_report_enable = st.error_counter_config[LEC_CFG_SIG_FBIT];

endmodule // lec_line_error_counters

//--- hw/lec_pkg.sv
package lec_pkg;

  // register map of the parallel port
  localparam logic [7:0] LEC_ADDR_CONFIG  = 8'h41;
  localparam logic [7:0] LEC_ADDR_COUNT_H = 8'h42;
  localparam logic [7:0] LEC_ADDR_COUNT_L = 8'h43;

  // configuration field positions
  localparam int LEC_CFG_EXCESS_ZERO  = 0;
  localparam int LEC_CFG_SYNC_FUNC    = 1;
  localparam int LEC_CFG_SIG_FBIT     = 2;
  localparam int LEC_CFG_E1_VIOL_TYPE = 3;
  localparam int LEC_CFG_ACC_SOURCE   = 4;
  localparam int LEC_CFG_AUTO_INTERVAL = 5;
  localparam int LEC_CFG_MANUAL       = 6;

  // reset values and masks
  localparam logic [7:0]  LEC_CFG_RESET      = 8'h00;
  localparam logic [7:0]  LEC_CFG_WRITE_MASK = 8'h7f;
  localparam logic [7:0]  LEC_RDATA_IDLE     = 8'h00;
  localparam logic [15:0] LEC_COUNT_RESET    = 16'h0000;
  localparam logic [15:0] LEC_COUNT_MAX      = 16'hffff;
  localparam logic [15:0] LEC_COUNT_ONE      = 16'h0001;

  // interval timing in frames of 125 us
  localparam int LEC_FRAME_PERIOD_US = 125;
  localparam int LEC_SECOND_US       = 1000000;
  localparam int LEC_SECOND_FRAMES   = LEC_SECOND_US / LEC_FRAME_PERIOD_US;
  localparam int LEC_T1_SHORT_FRAMES = 333;  // 42 ms
  localparam int LEC_E1_SHORT_FRAMES = 500;  // 62.5 ms
  localparam int LEC_FRAME_CNT_W     = 13;

  // excessive zero run lengths
  localparam int LEC_ZERO_RUN_PLAIN = 16;
  localparam int LEC_ZERO_RUN_B8ZS  = 8;
  localparam int LEC_ZERO_RUN_W     = 5;

  // one received line symbol from the line decoder
  typedef struct packed {
    logic bit_valid;  // one symbol this cycle
    logic pos;        // positive mark
    logic neg;        // negative mark
    logic subst;      // violation belongs to a valid substitution codeword
  } lec_line_s;

  // line mode from the framer configuration
  typedef struct packed {
    logic e1_mode;
    logic b8zs_en;
    logic hdb3_en;
    logic receive_loss_of_sync;
  } lec_mode_s;

  // parallel port request
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lec_port_s;

  // violation checker state
  typedef struct packed {
    logic                      have_mark;
    logic                      mark_neg;
    logic                      have_viol;
    logic                      viol_neg;
    logic [LEC_ZERO_RUN_W-1:0] zero_run;
    logic                      violation;
  } lec_check_s;

  // counter block state
  typedef struct packed {
    logic [7:0]                 error_counter_config;
    logic [15:0]                running;
    logic [15:0]                latched;
    logic [LEC_FRAME_CNT_W-1:0] frame_cnt;
    logic                       manual_pend;
    logic                       update_strobe;
    logic                       interval_tick;
    logic [7:0]                 rdata;
  } lec_main_s;

endpackage

//--- hw/lec_code_check.sv
`timescale 1ns/1ns
module lec_code_check
  import lec_pkg::*;
(
  input  wire logic      mclk,                  // system clock
  input  wire logic      reset,                 // synchronous reset
  input  wire lec_line_s line,                  // received symbol
  input  wire lec_mode_s mode,                  // line mode
  input  wire logic      excess_zero_count_enable, // t1 only: count long zero runs
  input  wire logic      e1_violation_type_select, // e1: 0 bpv, 1 cv
  output logic           violation              // one-cycle error event
);

  lec_check_s st;
  lec_check_s next_st;

  logic                      is_zero;
  logic                      is_pos;
  logic                      is_neg;
  logic                      is_mark;
  logic                      bpv;
  logic                      zero_hit;
  logic [LEC_ZERO_RUN_W-1:0] run_limit;

  // symbol decode and violation classification
  always_comb begin
    next_st   = st;
    is_pos    = line.bit_valid & line.pos & ~line.neg;
    is_neg    = line.bit_valid & line.neg & ~line.pos;
    is_mark   = is_pos | is_neg;
    is_zero   = line.bit_valid & ~line.pos & ~line.neg;
    bpv       = is_mark & st.have_mark & (is_neg == st.mark_neg);
    run_limit = mode.b8zs_en ? LEC_ZERO_RUN_W'(LEC_ZERO_RUN_B8ZS)
                             : LEC_ZERO_RUN_W'(LEC_ZERO_RUN_PLAIN);
    zero_hit  = is_zero & (st.zero_run == run_limit - LEC_ZERO_RUN_W'(1));
    next_st.violation = 1'b0;
    if (is_mark) begin
      next_st.have_mark = 1'b1;
      next_st.mark_neg  = is_neg;
      next_st.zero_run  = '0;
    end else if (is_zero && st.zero_run != run_limit) begin
      next_st.zero_run = st.zero_run + LEC_ZERO_RUN_W'(1);
    end
    if (!mode.e1_mode) begin
      next_st.violation = (bpv & ~(mode.b8zs_en & line.subst))
                        | (excess_zero_count_enable & zero_hit);
    end else if (!e1_violation_type_select) begin
      next_st.violation = bpv & ~(mode.hdb3_en & line.subst);
    end else begin
      next_st.violation = bpv & st.have_viol & (is_neg == st.viol_neg);
    end
    if (bpv) begin
      next_st.have_viol = 1'b1;
      next_st.viol_neg  = is_neg;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign violation = st.violation;

endmodule // lec_code_check

//--- verification/lec_line_error_counters_properties.sv
`timescale 1ns/1ns
// watches the counter block from its ports
module lec_line_error_counters_properties
  import lec_pkg::*;
#(
  parameter int SECOND_FRAMES   = LEC_SECOND_FRAMES,
  parameter int T1_SHORT_FRAMES = LEC_T1_SHORT_FRAMES,
  parameter int E1_SHORT_FRAMES = LEC_E1_SHORT_FRAMES
)
(
  input wire logic       mclk,                         // clock
  input wire logic       reset,                        // reset
  input wire lec_port_s  port,                         // request
  input wire logic [7:0] rdata,                        // read data
  input wire lec_mode_s  mode,                         // line mode
  input wire logic       frame_tick,                   // frame pulse
  input wire logic       update_strobe,                // update pulse
  input wire logic       interval_tick,                // timer tick
  input wire logic       sync_counter_function_select, // config bit 1
  input wire logic       signaling_fbit_report_enable  // config bit 2
);
  logic [7:0]  cfg;
  logic [12:0] fcnt;
  int          lim;
  logic        wcfg;
  logic        rcfg;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // config accesses and the interval length now selected
  assign wcfg = port.cs && port.wr && port.addr == LEC_ADDR_CONFIG;
  assign rcfg = port.cs && port.rd && port.addr == LEC_ADDR_CONFIG;
  assign lim  = !cfg[LEC_CFG_AUTO_INTERVAL] ? SECOND_FRAMES :
                mode.e1_mode ? E1_SHORT_FRAMES : T1_SHORT_FRAMES;
  // mirror of config and frames seen since the last timer tick
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg  <= LEC_CFG_RESET;
      fcnt <= '0;
    end else begin
      if (wcfg) cfg <= port.wdata & LEC_CFG_WRITE_MASK;
      if (cfg[LEC_CFG_ACC_SOURCE] || interval_tick) fcnt <= '0;
      else if (frame_tick) fcnt <= fcnt + 13'h1;
    end
  end
  rdata_idle_a: assert property (!$past(port.cs && port.rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  sync_follow_a: assert property (wcfg |=>
    sync_counter_function_select == $past(port.wdata[1])) else $error("bit 1 not output");
  fbit_follow_a: assert property (wcfg |=>
    signaling_fbit_report_enable == $past(port.wdata[2])) else $error("bit 2 not output");
  cfg_read_a: assert property ($past(rcfg) |-> rdata[7] == 1'b0 && rdata[2:1] ==
    {signaling_fbit_report_enable, sync_counter_function_select}) else $error("bad config");
  tick_strobe_a: assert property (interval_tick |-> update_strobe)
    else $error("tick without update");
  manual_upd_a: assert property (wcfg && cfg[4] && !cfg[6] && port.wdata[6]
    |-> ##2 update_strobe) else $error("manual update missing");
  auto_quiet_a: assert property (cfg[4] && $past(cfg[4]) |-> !interval_tick)
    else $error("timer tick in manual mode");
  interval_len_a: assert property (interval_tick |-> fcnt == lim)
    else $error("interval length wrong");
  interval_due_a: assert property (frame_tick && !cfg[4] && fcnt == lim - 1
    |=> interval_tick) else $error("interval update missing");
endmodule // lec_line_error_counters_properties

bind lec_line_error_counters lec_line_error_counters_properties #(
  .SECOND_FRAMES(SECOND_FRAMES), .T1_SHORT_FRAMES(T1_SHORT_FRAMES),
  .E1_SHORT_FRAMES(E1_SHORT_FRAMES)
) lec_props (.mclk(mclk), .reset(reset), .port(port), .rdata(rdata), .mode(mode),
  .frame_tick(frame_tick), .update_strobe(update_strobe), .interval_tick(interval_tick),
  .sync_counter_function_select(sync_counter_function_select),
  .signaling_fbit_report_enable(signaling_fbit_report_enable));

//--- verification/lec_line_model.sv
`timescale 1ns/1ns
// stand-in for the line decoder: symbols on request, periodic frames
module lec_line_model
  import lec_pkg::*;
#(
  parameter int FRAME_CYCLES = 8 // clocks per frame
)
(
  input  wire logic  mclk,      // clock
  input  wire logic  send,      // symbol request
  input  wire logic  p,         // positive mark
  input  wire logic  n,         // negative mark
  input  wire logic  s,         // substitution flag
  input  wire logic  frames_on, // frames run
  output lec_line_s  line,      // symbol out
  output logic       frame_tick // frame pulse
);
  int fc = 0;
  initial line = '0;
  initial frame_tick = 1'b0;
  // lanes flip between symbols so stale marks never look valid
  always @(posedge mclk) begin
    line.bit_valid <= send;
    line.pos       <= send ? p : ~line.pos;
    line.neg       <= send ? n : ~line.neg;
    line.subst     <= send ? s : ~line.subst;
  end
  // one frame pulse every FRAME_CYCLES while running
  always @(posedge mclk) begin
    fc         <= frames_on ? (fc + 1) % FRAME_CYCLES : 0;
    frame_tick <= frames_on && fc == FRAME_CYCLES - 1;
  end
endmodule // lec_line_model

//--- verification/lec_line_error_counters_tb_top.sv
`timescale 1ns/1ns
// register level bench for the error counter block
module lec_line_error_counters_tb_top
  import lec_pkg::*;
();
  localparam int FP = 8;
  localparam logic [2:0] P = 3'b100, N = 3'b010, Z = 3'b000, NS = 3'b011;
  logic       mclk = 1'b0, reset = 1'b1, send = 1'b0, p = 1'b0, n = 1'b0, s = 1'b0, fon = 1'b0;
  lec_port_s  pt = '0;
  lec_mode_s  md = '0;
  lec_line_s  line;
  logic [7:0] rdata, d, h, l;
  logic       ftick, ustr, itick, sync_sel, fbit_en;
  int         err_total = 0, check_count = 0, lim;
  time        t0;
  always #2 mclk = ~mclk;
  lec_line_model #(.FRAME_CYCLES(FP)) lec_line_model_i (.mclk(mclk), .send(send), .p(p),
    .n(n), .s(s), .frames_on(fon), .line(line), .frame_tick(ftick));
  lec_line_error_counters #(.SECOND_FRAMES(10), .T1_SHORT_FRAMES(4), .E1_SHORT_FRAMES(5))
    lec_line_error_counters_i (.mclk(mclk), .reset(reset), .port(pt), .rdata(rdata),
    .line(line), .mode(md), .frame_tick(ftick), .update_strobe(ustr), .interval_tick(itick),
    .sync_counter_function_select(sync_sel), .signaling_fbit_report_enable(fbit_en));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rst;
    @(negedge mclk);
    reset = 1'b1;
    fon = 1'b0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    pt = '{1'b1, 1'b0, 1'b1, a, v};
    @(negedge mclk);
    pt = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    pt = '{1'b1, 1'b1, 1'b0, a, 8'h00};
    @(negedge mclk);
    pt = '0;
    v = rdata;
  endtask
  // back-to-back symbols of one kind, then the line goes idle
  task automatic run(input logic [2:0] k, input int num);
    repeat (num) begin
      @(negedge mclk);
      send = 1'b1;
      {p, n, s} = k;
    end
    @(negedge mclk);
    send = 1'b0;
  endtask
  // manual update from config base, settle, then read both bytes
  task automatic cnt(input logic [7:0] base, input logic [15:0] exp);
    wr(LEC_ADDR_CONFIG, base | 8'h10);
    wr(LEC_ADDR_CONFIG, base | 8'h50);
    repeat (2) @(negedge mclk);
    rd(LEC_ADDR_COUNT_H, h);
    rd(LEC_ADDR_COUNT_L, l);
    chk({h, l}, exp);
  endtask
  task automatic wait_tick(input logic want);
    for (int i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (itick === 1'b1) begin
        chk({ustr, want}, 2'b11);
        return;
      end
    end
    chk(want, 1'b0);
    if (want) final_report();
  endtask
  initial begin
    rst();
    for (logic [7:0] a = 8'h41; a < 8'h45; a++) begin
      rd(a, d);
      chk(d, 8'h00);
    end
    wr(LEC_ADDR_COUNT_H, 8'hff);
    rd(LEC_ADDR_COUNT_H, d);
    chk(d, 8'h00);
    // software keeps the unused top bit at 0
    wr(LEC_ADDR_CONFIG, 8'h7f);
    rd(LEC_ADDR_CONFIG, d);
    chk({d, sync_sel, fbit_en}, {8'h7f, 2'b11});
    $display("test registers done");
    rst();
    md = '{1'b0, 1'b0, 1'b0, 1'b1};
    wr(LEC_ADDR_CONFIG, 8'h11);
    run(P, 1); run(N, 1); run(P, 2); run(N, 1);
    cnt(8'h01, 16'h0001);
    run(Z, 15); run(P, 1); run(Z, 16); run(N, 1);
    cnt(8'h01, 16'h0001);
    md.b8zs_en = 1'b1;
    run(NS, 1); run(Z, 8); run(P, 1);
    cnt(8'h01, 16'h0001);
    $display("test t1 counting done");
    rst();
    md = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(LEC_ADDR_CONFIG, 8'h10);
    run(P, 1); run(P | 3'b001, 1); run(P, 1);
    cnt(8'h00, 16'h0001);
    rst();
    // code violation counting on an hdb3 line
    md = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(LEC_ADDR_CONFIG, 8'h18);
    run(P, 3);
    cnt(8'h08, 16'h0001);
    // bipolar violation counting on an ami line
    md.hdb3_en = 1'b0;
    wr(LEC_ADDR_CONFIG, 8'h10);
    run(P, 3);
    cnt(8'h00, 16'h0003);
    $display("test e1 counting done");
    rst();
    md = '0;
    wr(LEC_ADDR_CONFIG, 8'h10);
    run(P, 65537);
    cnt(8'h00, 16'hffff);
    cnt(8'h00, 16'h0000);
    $display("test saturation done");
    for (int c = 0; c < 3; c++) begin
      rst();
      md = '0;
      md.e1_mode = (c == 2);
      lim = (c == 0) ? 10 : (c == 1) ? 4 : 5;
      wr(LEC_ADDR_CONFIG, (c > 0) ? 8'h20 : 8'h00);
      fon = 1'b1;
      wait_tick(1'b1);
      t0 = $time;
      run(P, 2);
      wait_tick(1'b1);
      chk(16'(($time - t0) / 4), 16'(lim * FP));
      rd(LEC_ADDR_COUNT_H, h);
      rd(LEC_ADDR_COUNT_L, l);
      chk({h, l}, 16'h0001);
    end
    wr(LEC_ADDR_CONFIG, 8'h30);
    wait_tick(1'b0);
    $display("test automatic update done");
    final_report();
  end
endmodule // lec_line_error_counters_tb_top
